//--- core/ttu_defines.svh
// constants of the trace unstable alarm and indirect access register block
// Operation
// R1 - tu3 status bits 0..6 report and acknowledge unstable events of groups 1..7
// R2 - tu4 status bits 0..6 report and acknowledge unstable events of groups 1..7
// R3 - in tu3 mode every tu3 and tu4 unstable status bit reads 0
// R4 - tu3 status bit reads 0 when its group is tu2 or vt3 size
// R5 - tu4 status bit reads 0 when its group is tu2, vt3 or tu12 size
// R6 - status bit sets on every change of unstable state, either direction
// R7 - reading a status register clears its set bits and acknowledges them
// R8 - status bits keep setting while the interrupt enable is low
// R9 - separate 16-byte and 64-byte thresholds, the one for the message length applies
// R10 - short threshold bits 3:0, long threshold bits 7:4, both reset to 0111
// R11 - alternate algorithm low: count each differing message, alarm when count exceeds threshold
// R12 - alternate algorithm high: differing message starts per-message counting, same alarm test
// R13 - three or five repeats accept the message, negate alarm and clear counter
// R14 - group index and tributary index choose the indirect target buffer
// R15 - page select high targets the capture page, latest message, no debouncing
// R16 - page select low targets the expected page; both pages read and write
// R17 - any address register write triggers an access at the 6-bit byte index; the code drops a write made while busy
// R18 - direction 0 writes the data register byte into the buffer
// R19 - direction 1 reads the byte into the data register
// R20 - busy rises on the triggering write and falls when the access completes
// R21 - software polls busy low before reading data or starting another write
// R22 - software loads the data register before a write; it holds read data after
// R23 - interrupt request while any status bit set and enable high
`ifndef TTU_DEFINES_SVH
`define TTU_DEFINES_SVH
`define TTU_A_ST3      12'h426
`define TTU_A_ST4      12'h427
`define TTU_A_THR      12'h428
`define TTU_A_TSEL     12'h429
`define TTU_A_ADDR     12'h42a
`define TTU_A_DATA     12'h42b
`define TTU_THR_RST    4'h7
`define TTU_PER_SHORT  3'h3
`define TTU_PER_LONG   3'h5
`define TTU_CNT_MAX    5'h1f
`define TTU_NGRP       7
`define TTU_NTRIB      14
`define TTU_SZ_TU11    2'h0
`define TTU_SZ_TU12    2'h1
`define TTU_SZ_VT3     2'h2
`define TTU_SZ_TU2     2'h3
`endif

//--- core/ttu_pkg.sv
// types of the trace unstable alarm and indirect access register block
package ttu_pkg;
  typedef enum logic {ENG_IDLE, ENG_WAIT} ttu_eng_e;
  typedef struct packed {
    logic [3:0]        thr16;
    logic [3:0]        thr64;
    logic              page;
    logic [2:0]        grp;
    logic [1:0]        trib;
    logic              dir;
    logic [5:0]        byte_idx;
    ttu_eng_e          eng;
    logic [7:0]        data;
    logic [7:0]        rdata;
    logic [6:0]        st3;
    logic [6:0]        st4;
    logic [13:0]       alarm;
    logic [13:0]       active;
    logic [13:0][4:0]  ucnt;
    logic [13:0][2:0]  pcnt;
  } ttu_state_s;
endpackage : ttu_pkg

//--- core/ttu_regs.sv
// trace unstable status, thresholds, counters and indirect buffer access
`timescale 1ns/1ps
`default_nettype none
`include "ttu_defines.svh"
module ttu_regs
  import ttu_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // microprocessor port, synchronous strobes
  input  wire logic [11:0]       up_addr,
  input  wire logic              up_wr,
  input  wire logic              up_rd,
  input  wire logic [7:0]        up_wdata,
  output logic      [7:0]        up_rdata,
  // configuration
  input  wire logic              tu3_mode,
  input  wire logic [6:0][1:0]   group_size,
  input  wire logic              long_msg,
  input  wire logic              alternate_algorithm_select,
  input  wire logic              persistence_five_select,
  input  wire logic              unstable_interrupt_enable,
  // received messages, index 0..6 tu3 of groups, 7..13 tu4 of groups
  input  wire logic [13:0]       msg_done,
  input  wire logic [13:0]       msg_differs,
  output logic      [13:0]       trace_unstable_alarm,
  output logic                   unstable_irq,
  // trace buffer port
  output logic                   buf_req,
  output logic                   buf_we,
  output logic                   buf_page,
  output logic      [2:0]        buf_grp,
  output logic      [1:0]        buf_trib,
  output logic      [5:0]        buf_byte,
  output logic      [7:0]        buf_wdata,
  input  wire logic [7:0]        buf_rdata,
  input  wire logic              buf_ack
);

  ttu_state_s st_ff;
  ttu_state_s nxt_st;

  // per-group validity of the third and fourth tributary
  function automatic logic [6:0] valid_mask(input logic [6:0][1:0] sz,
                                            input logic            tu3,
                                            input logic            fourth);
    logic [6:0] m;
    m = '0;
    for (int g = 0; g < `TTU_NGRP; g++) begin
      if (fourth) begin
        m[g] = (sz[g] == `TTU_SZ_TU11); // R5
      end else begin
        m[g] = (sz[g] == `TTU_SZ_TU11) || (sz[g] == `TTU_SZ_TU12); // R4
      end
    end
    return tu3 ? 7'h00 : m; // R3
  endfunction : valid_mask

  // saturating increment of the unstable counter
  function automatic logic [4:0] cnt_inc(input logic [4:0] c);
    return (c == `TTU_CNT_MAX) ? c : c + 5'h01;
  endfunction : cnt_inc

  logic [6:0]  v3;
  logic [6:0]  v4;
  logic [3:0]  thr_act;
  logic [2:0]  per_need;
  logic [13:0] chg;
  logic        hit_wr;

  assign v3       = valid_mask(group_size, tu3_mode, 1'b0);
  assign v4       = valid_mask(group_size, tu3_mode, 1'b1);
  assign thr_act  = long_msg ? st_ff.thr64 : st_ff.thr16; // R9
  assign per_need = persistence_five_select ? `TTU_PER_LONG : `TTU_PER_SHORT;

  always_comb begin
    logic [4:0] c;
    logic [2:0] p;
    c      = '0;
    p      = '0;
    nxt_st = st_ff;
    chg    = '0;
    hit_wr = 1'b0;

    // unstable counters, one per tributary
    for (int i = 0; i < `TTU_NTRIB; i++) begin
      c = st_ff.ucnt[i];
      p = st_ff.pcnt[i];
      if (msg_done[i]) begin
        if (msg_differs[i]) begin
          c = cnt_inc(c); // R11
          p = 3'h1;
          nxt_st.active[i] = 1'b1;
        end else begin
          if (alternate_algorithm_select && st_ff.active[i]) begin
            c = cnt_inc(c); // R12
          end
          if (p < per_need) begin
            p = p + 3'h1;
          end
        end
        if (p >= per_need) begin
          c = '0; // R13
          nxt_st.active[i] = 1'b0;
          nxt_st.alarm[i]  = 1'b0;
        end else if (c > {1'b0, thr_act}) begin
          nxt_st.alarm[i] = 1'b1; // R11 R12
        end
      end
      nxt_st.ucnt[i] = c;
      nxt_st.pcnt[i] = p;
      chg[i] = nxt_st.alarm[i] != st_ff.alarm[i]; // R6
    end

    // read clears, a same-cycle event wins over the clear
    if (up_rd && (up_addr == `TTU_A_ST3)) begin
      nxt_st.st3 = '0; // R7
    end
    if (up_rd && (up_addr == `TTU_A_ST4)) begin
      nxt_st.st4 = '0; // R7
    end
    // status sets regardless of the interrupt enable
    nxt_st.st3 = nxt_st.st3 | (chg[6:0] & v3);  // R1 R8
    nxt_st.st4 = nxt_st.st4 | (chg[13:7] & v4); // R2 R8

    // register writes
    if (up_wr) begin
      case (up_addr)
        `TTU_A_THR: begin
          nxt_st.thr16 = up_wdata[3:0]; // R10
          nxt_st.thr64 = up_wdata[7:4]; // R10
        end
        `TTU_A_TSEL: begin
          nxt_st.page = up_wdata[7]; // R15 R16
          nxt_st.grp  = up_wdata[4:2]; // R14
          nxt_st.trib = up_wdata[1:0]; // R14
        end
        `TTU_A_ADDR: begin
          hit_wr = 1'b1;
        end
        `TTU_A_DATA: begin
          // a write here while a read is pending is overwritten by the fetch
          nxt_st.data = up_wdata;
        end
        default: begin
          nxt_st.data = nxt_st.data;
        end
      endcase
    end

    // indirect access engine
    case (st_ff.eng)
      ENG_IDLE: begin
        if (hit_wr) begin
          nxt_st.dir      = up_wdata[6]; // R18 R19
          nxt_st.byte_idx = up_wdata[5:0]; // R17
          nxt_st.eng      = ENG_WAIT; // R17 R20
        end
      end
      ENG_WAIT: begin
        // new triggers are dropped while busy; software waits for busy low
        if (buf_ack) begin
          nxt_st.eng = ENG_IDLE; // R20
          if (st_ff.dir) begin
            nxt_st.data = buf_rdata; // R19 R22
          end
        end
      end
      default: begin
        nxt_st.eng = ENG_IDLE;
      end
    endcase

    // registered read data
    nxt_st.rdata = '0;
    if (up_rd) begin
      case (up_addr)
        `TTU_A_ST3:  nxt_st.rdata = {1'b0, st_ff.st3 & v3}; // R1 R3 R4
        `TTU_A_ST4:  nxt_st.rdata = {1'b0, st_ff.st4 & v4}; // R2 R3 R5
        `TTU_A_THR:  nxt_st.rdata = {st_ff.thr64, st_ff.thr16};
        `TTU_A_TSEL: nxt_st.rdata = {st_ff.page, 2'b00, st_ff.grp, st_ff.trib};
        `TTU_A_ADDR: nxt_st.rdata = {st_ff.eng == ENG_WAIT, st_ff.dir,
                                     st_ff.byte_idx}; // R20
        `TTU_A_DATA: nxt_st.rdata = st_ff.data;
        default:     nxt_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_ff          <= '0;
      st_ff.thr16    <= `TTU_THR_RST; // R10
      st_ff.thr64    <= `TTU_THR_RST; // R10
      st_ff.eng      <= ENG_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign up_rdata             = st_ff.rdata;
  assign trace_unstable_alarm = st_ff.alarm;
  // request follows the sticky bits, so reads drop it
  assign unstable_irq         = unstable_interrupt_enable &&
                                (|(st_ff.st3 & v3) || |(st_ff.st4 & v4)); // R23
  // buffer request held until acknowledged
  assign buf_req   = (st_ff.eng == ENG_WAIT);
  assign buf_we    = !st_ff.dir; // R18
  assign buf_page  = st_ff.page; // R15 R16
  assign buf_grp   = st_ff.grp; // R14
  assign buf_trib  = st_ff.trib; // R14
  assign buf_byte  = st_ff.byte_idx; // R17
  assign buf_wdata = st_ff.data; // R18

endmodule : ttu_regs
`default_nettype wire

//--- sim/ttu_regs_props.sv
// assertions on the ports of the trace unstable register block
`timescale 1ns/1ps
`default_nettype none
module ttu_regs_props (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [11:0] up_addr,
  input wire logic        up_wr,
  input wire logic        up_rd,
  input wire logic [7:0]  up_wdata,
  input wire logic [7:0]  up_rdata,
  input wire logic        tu3_mode,
  input wire logic [13:0] msg_done,
  input wire logic [13:0] trace_unstable_alarm,
  input wire logic        unstable_irq,
  input wire logic        unstable_interrupt_enable,
  input wire logic        buf_req,
  input wire logic        buf_we,
  input wire logic [5:0]  buf_byte,
  input wire logic        buf_ack
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  rd_idle_a: assert property (!$past(up_rd) |-> up_rdata == 8'h00)
    else $error("read data not zero outside a read");
  st_top_a: assert property ($past(up_rd) && $past(up_addr[11:1]) == 11'h213 |-> !up_rdata[7])
    else $error("status bit 7 not zero");
  tu3_mask_a: assert property ($past(up_rd) && $past(tu3_mode) && $past(up_addr[11:1]) == 11'h213
    |-> up_rdata == 8'h00)
    else $error("status not masked in tu3 mode");
  busy_rise_a: assert property (up_wr && up_addr == 12'h42a && !buf_req |=> buf_req
    && buf_byte == $past(up_wdata[5:0]) && buf_we == !$past(up_wdata[6]))
    else $error("trigger did not start the access");
  busy_fall_a: assert property (buf_req && buf_ack |=> !buf_req)
    else $error("busy stayed after completion");
  busy_hold_a: assert property (buf_req && !buf_ack |=> buf_req && $stable(buf_byte))
    else $error("access dropped before completion");
  irq_gate_a: assert property (unstable_irq |-> unstable_interrupt_enable)
    else $error("request without enable");
  alarm_cause_a: assert property ($past(nrst) |-> ((trace_unstable_alarm
    ^ $past(trace_unstable_alarm)) & ~$past(msg_done)) == 14'h0)
    else $error("alarm moved without a message");
  cover property (buf_req && buf_ack);
  cover property ($rose(trace_unstable_alarm[0]));
  cover property (unstable_irq);
endmodule : ttu_regs_props
`default_nettype wire

//--- sim/ttu_regs_tb.sv
// self-checking bench of the trace unstable register block
`timescale 1ns/1ps
`default_nettype none
module ttu_regs_tb;
  logic sys_clk, nrst, up_wr, up_rd;
  logic tu3_mode, long_msg, alternate_algorithm_select, persistence_five_select;
  logic unstable_interrupt_enable, unstable_irq, buf_req, buf_we, buf_page, buf_ack;
  logic [11:0] up_addr;
  logic [7:0] up_wdata, up_rdata, buf_wdata, buf_rdata, r, t;
  logic [6:0][1:0] group_size;
  logic [13:0] msg_done, msg_differs, trace_unstable_alarm;
  logic [2:0] buf_grp;
  logic [1:0] buf_trib;
  logic [5:0] buf_byte;
  integer err_total = 0, cmp_count = 0, seed = 32'h9eae;
  ttu_regs i_ttu_regs (.sys_clk, .nrst, .up_addr, .up_wr, .up_rd, .up_wdata, .up_rdata,
    .tu3_mode, .group_size, .long_msg, .alternate_algorithm_select, .persistence_five_select,
    .unstable_interrupt_enable, .msg_done, .msg_differs, .trace_unstable_alarm, .unstable_irq,
    .buf_req, .buf_we, .buf_page, .buf_grp, .buf_trib, .buf_byte, .buf_wdata, .buf_rdata,
    .buf_ack);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    up_addr = a;
    up_wdata = d;
    up_wr = 1'b1;
    @(negedge sys_clk);
    up_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
    @(negedge sys_clk);
    up_addr = a;
    up_rd = 1'b1;
    @(negedge sys_clk);
    up_rd = 1'b0;
    chk(n, {6'h0, e}, {6'h0, up_rdata});
  endtask : rd
  task automatic msg(input logic [13:0] m, input logic [13:0] d, input int n);
    repeat (n) begin
      @(negedge sys_clk);
      msg_done = m;
      msg_differs = d;
      @(negedge sys_clk);
      msg_done = 14'h0;
    end
  endtask : msg
  // valid status bits; tu4 only in tu11 groups, tu3 in tu11 and tu12 groups
  function automatic logic [7:0] vmask(input logic four);
    vmask = 8'h00;
    for (int g = 0; g < 7; g++)
      vmask[g] = !tu3_mode && (four ? group_size[g] == 2'h0 : group_size[g] <= 2'h1);
  endfunction : vmask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial begin
    {up_addr, up_wdata, up_wr, up_rd, tu3_mode, long_msg, buf_rdata, buf_ack} = '0;
    {alternate_algorithm_select, persistence_five_select, unstable_interrupt_enable} = '0;
    {group_size, msg_done, msg_differs, nrst} = '0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    rd(12'h428, 8'h77, "threshold");
    rd(12'h426, 8'h00, "st3");
    rd(12'h430, 8'h00, "unmapped");
    r = $random(seed);
    wr(12'h428, r);
    rd(12'h428, r, "threshold");
    wr(12'h428, 8'h52);
    $display("test registers done");
    msg(14'h1, 14'h1, 2);
    chk("alarm", 14'h0, trace_unstable_alarm);
    msg(14'h1, 14'h1, 1);
    chk("alarm", 14'h1, trace_unstable_alarm);
    chk("irq", 14'h0, {13'h0, unstable_irq});
    rd(12'h426, 8'h01, "st3");
    rd(12'h426, 8'h00, "st3");
    unstable_interrupt_enable = 1'b1;
    msg(14'h1, 14'h0, 1);
    chk("alarm", 14'h1, trace_unstable_alarm);
    msg(14'h1, 14'h0, 1);
    chk("alarm", 14'h0, trace_unstable_alarm);
    chk("irq", 14'h1, {13'h0, unstable_irq});
    rd(12'h426, 8'h01, "st3");
    chk("irq", 14'h0, {13'h0, unstable_irq});
    long_msg = 1'b1;
    msg(14'h80, 14'h80, 5);
    chk("alarm", 14'h0, trace_unstable_alarm);
    msg(14'h80, 14'h80, 1);
    chk("alarm", 14'h80, trace_unstable_alarm);
    rd(12'h427, 8'h01, "st4");
    msg(14'h80, 14'h0, 2);
    rd(12'h427, 8'h01, "st4");
    long_msg = 1'b0;
    // per-message counting and five repeats, on the second tributary
    alternate_algorithm_select = 1'b1;
    persistence_five_select = 1'b1;
    msg(14'h2, 14'h2, 1);
    msg(14'h2, 14'h0, 2);
    chk("alarm", 14'h2, trace_unstable_alarm);
    msg(14'h2, 14'h0, 1);
    chk("alarm", 14'h2, trace_unstable_alarm);
    msg(14'h2, 14'h0, 1);
    chk("alarm", 14'h0, trace_unstable_alarm);
    rd(12'h426, 8'h02, "st3");
    {alternate_algorithm_select, persistence_five_select} = 2'b00;
    $display("test alarm done");
    for (int m = 0; m < 2; m++) begin
      tu3_mode = m[0];
      group_size = 14'($random(seed));
      msg(14'h3fff, 14'h3fff, 3);
      rd(12'h426, vmask(1'b0), "st3");
      rd(12'h427, vmask(1'b1), "st4");
      msg(14'h3fff, 14'h0, 2);
      chk("alarm", 14'h0, trace_unstable_alarm);
      rd(12'h426, vmask(1'b0), "st3");
      rd(12'h427, vmask(1'b1), "st4");
    end
    $display("test masking done");
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      // both pages reached, each with a read and a write
      t = {k[1], 2'b00, 5'($random(seed))};
      wr(12'h429, t);
      wr(12'h42b, r);
      wr(12'h42a, {1'b0, k[0], t[5:0] ^ 6'h2a});
      chk("req", 14'h1, {13'h0, buf_req});
      chk("target", {1'b0, ~k[0], t[7], t[4:0], t[5:0] ^ 6'h2a},
        {1'b0, buf_we, buf_page, buf_grp, buf_trib, buf_byte});
      wr(12'h42a, 8'h3f);
      rd(12'h42a, {1'b1, k[0], t[5:0] ^ 6'h2a}, "busy");
      chk("wdata", {6'h0, r}, {6'h0, buf_wdata});
      @(negedge sys_clk);
      buf_rdata = ~r;
      buf_ack = 1'b1;
      @(negedge sys_clk);
      buf_ack = 1'b0;
      buf_rdata = r;
      rd(12'h42a, {1'b0, k[0], t[5:0] ^ 6'h2a}, "idle");
      rd(12'h42b, k[0] ? ~r : r, "data");
    end
    $display("test indirect done");
    // reset in mid-run with an access pending
    wr(12'h42a, 8'h45);
    @(negedge sys_clk);
    nrst = 1'b0;
    @(negedge sys_clk);
    nrst = 1'b1;
    chk("req", 14'h0, {13'h0, buf_req});
    rd(12'h428, 8'h77, "threshold");
    $display("test reset done");
    conclude();
  end
endmodule : ttu_regs_tb
bind ttu_regs ttu_regs_props i_ttu_regs_props (.sys_clk, .nrst, .up_addr, .up_wr, .up_rd,
  .up_wdata, .up_rdata, .tu3_mode, .msg_done, .trace_unstable_alarm, .unstable_irq,
  .unstable_interrupt_enable, .buf_req, .buf_we, .buf_byte, .buf_ack);
`default_nettype wire
